/* File: common/clk_ctrl_pkg.sv */
// Purpose: shared constants and types of the clock buffer control logic
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes: configuration is held in a small register file reached by port
package clk_ctrl_pkg;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int NUM_BANKS = 10;
   localparam int NUM_OUTS = 20;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;

   // ----------------------------------------------------------------
   // register offsets (word index, byte address is four times this)
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] REG_CONTROL = 5'h00;
   localparam logic [ADDR_W-1:0] REG_STATUS = 5'h01;
   localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 5'h02;
   localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 5'h03;
   localparam logic [ADDR_W-1:0] REG_DIVIDE = 5'h04;
   localparam logic [ADDR_W-1:0] REG_LOCK_COUNT = 5'h05;
   localparam logic [ADDR_W-1:0] REG_OUT_BASE = 5'h08;
   localparam logic [ADDR_W-1:0] REG_BANK_STD = 5'h06;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CTRL_LOCK_CLEAR_BIT = 0;
   localparam int STAT_LOCK_BIT = 0;
   localparam int STAT_BYPASS_BIT = 1;
   localparam int STAT_REF_INPUT_SELECT_BIT = 2;
   localparam int STAT_RESET_BIT = 3;
   localparam int IRQ_LOCK_GAIN_BIT = 0;
   localparam int IRQ_LOCK_LOSS_BIT = 1;
   localparam int IRQ_W = 2;
   localparam int OUT_MODE_LSB = 0;
   localparam int OUT_IMP_LSB = 2;
   localparam int OUT_SLEW_BIT = 5;
   localparam int BANK_STD_W = 3;

   // ----------------------------------------------------------------
   // reset values and timing
   // ----------------------------------------------------------------
   localparam logic [4:0] DIVIDE_RESET = 5'h00;
   localparam logic [15:0] LOCK_COUNT_RESET = 16'h0040;
   localparam logic [1:0] OUT_MODE_RESET = 2'h0;
   localparam logic [2:0] OUT_IMP_RESET = 3'h0;
   localparam logic [2:0] BANK_STD_RESET = 3'h0;
   localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h00000000;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      OE_ALWAYS_ON,
      OE_ALWAYS_OFF,
      OE_BY_X,
      OE_BY_Y
   } oe_mode_t;

   typedef struct packed {
      oe_mode_t mode;
      logic [2:0] impedance;
      logic slew_fast;
   } out_cfg_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic ref_input_select;
      logic pll_bypass;
      logic reset_n;
      logic out_enable_x_n;
      logic out_enable_y_n;
   } ctrl_pins_t;

endpackage : clk_ctrl_pkg

/* File: src/pow2_divider.sv */
// Purpose: power-of-two divider of the selected divider source, clocked by ref_clk
// Assumes: source arrives as a level sampled on ref_clk
// Notes: counts rising source edges; counter clears on clear or on the device reset
`timescale 1ns/100ps
`default_nettype none
module pow2_divider (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clear,
   input wire logic src,
   input wire logic [4:0] div_sel,
   output logic div_out
);
   typedef struct packed {
      logic src_d;
      logic [31:0] count;
      logic out;
   } div_state_t;

   div_state_t state_ff;
   div_state_t nxt_state;

   always_comb begin
      nxt_state = state_ff;
      nxt_state.src_d = src;
      if (clear) begin
         nxt_state.count = '0;
      end else if (src && !state_ff.src_d) begin
         nxt_state.count = state_ff.count + 32'h00000001;
      end
      nxt_state.out = (div_sel == 5'h00) ? src : nxt_state.count[div_sel - 5'h01];
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign div_out = state_ff.out;
endmodule : pow2_divider
`default_nettype wire

/* File: src/clk_buffer_ctrl.sv */
// Purpose: control logic of a zero-delay clock fan-out buffer
// Assumes: control pins synchronous to ref_clk; loop lock comes in as level
// Notes: output drivers use low-active enables; analog loop is outside
//
// Operation
// [R1] reference select low picks input a, high picks input b
// [R2] lock output high while the loop is locked, low otherwise
// [R3] the two enable pins switch outputs between driving and high impedance
// [R4] each output: always on, always off, by enable x, or by enable y
// [R5] bypass low: dividers run from the oscillator output
// [R6] bypass high: dividers run from the selected reference directly
// [R7] reset pin low clears all counters and drops the lock indication
// [R8] driver standard per bank of two, impedance and slew per output
// [R9] board holds reset pin inactive with a pull-up when not driving it
`timescale 1ns/100ps
`default_nettype none
module clk_buffer_ctrl (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ref_clock_a_in,
   input wire logic ref_clock_b_in,
   input wire logic feedback_in,
   input wire logic vco_in,
   input wire logic loop_locked_in,
   input wire clk_ctrl_pkg::ctrl_pins_t pins,
   input wire clk_ctrl_pkg::reg_req_t req,
   output logic [clk_ctrl_pkg::DATA_W-1:0] rdata,
   output logic lock,
   output logic irq,
   output logic [clk_ctrl_pkg::NUM_OUTS-1:0] clk_out,
   output logic [clk_ctrl_pkg::NUM_OUTS-1:0] clk_out_oe_n,
   output logic [clk_ctrl_pkg::NUM_OUTS-1:0] slew_fast,
   output logic [3*clk_ctrl_pkg::NUM_OUTS-1:0] out_impedance,
   output logic [3*clk_ctrl_pkg::NUM_BANKS-1:0] bank_std
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      clk_ctrl_pkg::out_cfg_t [clk_ctrl_pkg::NUM_OUTS-1:0] out_cfg;
      logic [clk_ctrl_pkg::NUM_BANKS-1:0][2:0] bank;
      logic [4:0] divide;
      logic [15:0] lock_count;
      logic [15:0] lock_timer;
      logic locked;
      logic lock_d;
      logic [clk_ctrl_pkg::IRQ_W-1:0] irq_status;
      logic [clk_ctrl_pkg::IRQ_W-1:0] irq_mask;
      logic [clk_ctrl_pkg::DATA_W-1:0] rdata;
      logic irq;
      logic [clk_ctrl_pkg::NUM_OUTS-1:0] oe_n;
      logic [clk_ctrl_pkg::NUM_OUTS-1:0] clk;
   } ctrl_state_t;

   ctrl_state_t state_ff;
   ctrl_state_t nxt_state;
   logic sel_ref;
   logic div_src;
   logic div_clk;
   logic counters_clear;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic oe_active(
      input clk_ctrl_pkg::oe_mode_t mode,
      input logic en_x_n,
      input logic en_y_n
   );
      logic res;
      res = 1'b0;
      case (mode)
         clk_ctrl_pkg::OE_ALWAYS_ON: res = 1'b1;
         clk_ctrl_pkg::OE_ALWAYS_OFF: res = 1'b0;
         clk_ctrl_pkg::OE_BY_X: res = !en_x_n;
         clk_ctrl_pkg::OE_BY_Y: res = !en_y_n;
         default: res = 1'b0;
      endcase
      return res;
   endfunction : oe_active

   // ----------------------------------------------------------------
   // clock path
   // ----------------------------------------------------------------
   assign sel_ref = pins.ref_input_select ? ref_clock_b_in : ref_clock_a_in; // [R1]
   // bypass takes the reference straight to the dividers
   assign div_src = pins.pll_bypass ? sel_ref : vco_in; // [R5] [R6]
   assign counters_clear = rst || !pins.reset_n; // [R7]

   pow2_divider u_div (
      .ref_clk(ref_clk),
      .rst(rst),
      .clear(counters_clear),
      .src(div_src),
      .div_sel(state_ff.divide),
      .div_out(div_clk)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [clk_ctrl_pkg::IRQ_W-1:0] events;
      logic [clk_ctrl_pkg::ADDR_W-1:0] idx;
      events = '0;
      idx = '0;
      nxt_state = state_ff;

      // lock qualification: loop must report lock for lock_count + 1 cycles
      // feedback is unused here; phase compare lives in the analog loop
      if (!pins.reset_n || pins.pll_bypass || !loop_locked_in) begin
         nxt_state.lock_timer = '0; // [R7]
         nxt_state.locked = 1'b0; // [R2] [R7]
      end else if (state_ff.lock_timer >= state_ff.lock_count) begin
         nxt_state.locked = 1'b1; // [R2]
      end else begin
         nxt_state.lock_timer = state_ff.lock_timer + 16'h0001;
      end
      nxt_state.lock_d = state_ff.locked;
      events[clk_ctrl_pkg::IRQ_LOCK_GAIN_BIT] = state_ff.locked && !state_ff.lock_d;
      events[clk_ctrl_pkg::IRQ_LOCK_LOSS_BIT] = !state_ff.locked && state_ff.lock_d;

      // register writes
      if (req.wr) begin
         if (req.addr == clk_ctrl_pkg::REG_IRQ_STATUS) begin
            nxt_state.irq_status = state_ff.irq_status
               & ~req.wdata[clk_ctrl_pkg::IRQ_W-1:0];
         end else if (req.addr == clk_ctrl_pkg::REG_IRQ_MASK) begin
            nxt_state.irq_mask = req.wdata[clk_ctrl_pkg::IRQ_W-1:0];
         end else if (req.addr == clk_ctrl_pkg::REG_DIVIDE) begin
            nxt_state.divide = req.wdata[4:0];
         end else if (req.addr == clk_ctrl_pkg::REG_LOCK_COUNT) begin
            nxt_state.lock_count = req.wdata[15:0];
         end else if (req.addr == clk_ctrl_pkg::REG_BANK_STD) begin
            for (int b = 0; b < clk_ctrl_pkg::NUM_BANKS; b++) begin
               nxt_state.bank[b] = req.wdata[3*b +: 3]; // [R8]
            end
         end else if (req.addr >= clk_ctrl_pkg::REG_OUT_BASE) begin
            idx = req.addr - clk_ctrl_pkg::REG_OUT_BASE;
            if (idx < 5'(clk_ctrl_pkg::NUM_OUTS)) begin
               nxt_state.out_cfg[idx].mode = clk_ctrl_pkg::oe_mode_t'(
                  req.wdata[clk_ctrl_pkg::OUT_MODE_LSB +: 2]); // [R4]
               nxt_state.out_cfg[idx].impedance =
                  req.wdata[clk_ctrl_pkg::OUT_IMP_LSB +: 3]; // [R8]
               nxt_state.out_cfg[idx].slew_fast =
                  req.wdata[clk_ctrl_pkg::OUT_SLEW_BIT]; // [R8]
            end
         end
      end
      // set wins over a clear in the same cycle
      nxt_state.irq_status = nxt_state.irq_status | events;
      nxt_state.irq = |(nxt_state.irq_status & nxt_state.irq_mask);

      // register reads, data in the following cycle only
      nxt_state.rdata = clk_ctrl_pkg::UNMAPPED_READ;
      if (req.rd) begin
         if (req.addr == clk_ctrl_pkg::REG_STATUS) begin
            nxt_state.rdata[clk_ctrl_pkg::STAT_LOCK_BIT] = state_ff.locked;
            nxt_state.rdata[clk_ctrl_pkg::STAT_BYPASS_BIT] = pins.pll_bypass;
            nxt_state.rdata[clk_ctrl_pkg::STAT_REF_INPUT_SELECT_BIT] =
               pins.ref_input_select;
            nxt_state.rdata[clk_ctrl_pkg::STAT_RESET_BIT] = !pins.reset_n;
         end else if (req.addr == clk_ctrl_pkg::REG_IRQ_STATUS) begin
            nxt_state.rdata[clk_ctrl_pkg::IRQ_W-1:0] = state_ff.irq_status;
         end else if (req.addr == clk_ctrl_pkg::REG_IRQ_MASK) begin
            nxt_state.rdata[clk_ctrl_pkg::IRQ_W-1:0] = state_ff.irq_mask;
         end else if (req.addr == clk_ctrl_pkg::REG_DIVIDE) begin
            nxt_state.rdata[4:0] = state_ff.divide;
         end else if (req.addr == clk_ctrl_pkg::REG_LOCK_COUNT) begin
            nxt_state.rdata[15:0] = state_ff.lock_count;
         end else if (req.addr == clk_ctrl_pkg::REG_BANK_STD) begin
            for (int b = 0; b < clk_ctrl_pkg::NUM_BANKS; b++) begin
               nxt_state.rdata[3*b +: 3] = state_ff.bank[b];
            end
         end else if (req.addr >= clk_ctrl_pkg::REG_OUT_BASE) begin
            idx = req.addr - clk_ctrl_pkg::REG_OUT_BASE;
            if (idx < 5'(clk_ctrl_pkg::NUM_OUTS)) begin
               nxt_state.rdata[clk_ctrl_pkg::OUT_MODE_LSB +: 2] =
                  state_ff.out_cfg[idx].mode;
               nxt_state.rdata[clk_ctrl_pkg::OUT_IMP_LSB +: 3] =
                  state_ff.out_cfg[idx].impedance;
               nxt_state.rdata[clk_ctrl_pkg::OUT_SLEW_BIT] =
                  state_ff.out_cfg[idx].slew_fast;
            end
         end
      end

      // output drivers; enable is low while driving
      for (int o = 0; o < clk_ctrl_pkg::NUM_OUTS; o++) begin
         nxt_state.oe_n[o] = !oe_active(state_ff.out_cfg[o].mode,
            pins.out_enable_x_n, pins.out_enable_y_n); // [R3] [R4]
         nxt_state.clk[o] = div_clk;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_ff <= '0;
         state_ff.lock_count <= clk_ctrl_pkg::LOCK_COUNT_RESET;
         state_ff.divide <= clk_ctrl_pkg::DIVIDE_RESET;
         state_ff.oe_n <= '1;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign rdata = state_ff.rdata;
   assign lock = state_ff.locked; // [R2]
   assign irq = state_ff.irq;
   assign clk_out = state_ff.clk;
   assign clk_out_oe_n = state_ff.oe_n; // [R3]
   always_comb begin
      for (int o = 0; o < clk_ctrl_pkg::NUM_OUTS; o++) begin
         slew_fast[o] = state_ff.out_cfg[o].slew_fast;
         out_impedance[3*o +: 3] = state_ff.out_cfg[o].impedance;
      end
      for (int b = 0; b < clk_ctrl_pkg::NUM_BANKS; b++) begin
         bank_std[3*b +: 3] = state_ff.bank[b]; // [R8]
      end
   end
endmodule : clk_buffer_ctrl
`default_nettype wire

/* File: testbench/clk_buffer_ctrl_assertions.sv */
// Purpose: port checker for the clock buffer control block
// Assumes: one clock, synchronous active-high reset
// Notes: sees only top-level ports; register contents are not visible
`timescale 1ns/100ps
`default_nettype none
module clk_buffer_ctrl_assertions (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic loop_locked_in,
   input wire clk_ctrl_pkg::ctrl_pins_t pins,
   input wire clk_ctrl_pkg::reg_req_t req,
   input wire logic [clk_ctrl_pkg::DATA_W-1:0] rdata,
   input wire logic lock,
   input wire logic irq,
   input wire logic [clk_ctrl_pkg::NUM_OUTS-1:0] clk_out_oe_n,
   input wire logic [clk_ctrl_pkg::NUM_OUTS-1:0] slew_fast,
   input wire logic [3*clk_ctrl_pkg::NUM_OUTS-1:0] out_impedance,
   input wire logic [3*clk_ctrl_pkg::NUM_BANKS-1:0] bank_std
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_reset_idle: assert property ($fell(rst) |-> !lock && !irq)
      else $error("lock or irq high after reset");
   a_reset_hiz: assert property ($fell(rst) |-> &clk_out_oe_n)
      else $error("outputs driving after reset");
   a_cfg_reset: assert property ($fell(rst) |->
      slew_fast == 0 && out_impedance == 0 && bank_std == 0)
      else $error("driver settings not cleared by reset");
   a_rd_stands: assert property (!$past(req.rd) |-> rdata == 0)
      else $error("read data outside its cycle");
   a_lock_cause: assert property (lock |->
      $past(loop_locked_in) && $past(pins.reset_n))
      else $error("lock high without a locked loop");
   a_pin_reset: assert property (!pins.reset_n |=> !lock)
      else $error("lock kept while reset pin low");
   a_bypass_unlock: assert property (pins.pll_bypass |=> !lock)
      else $error("lock high in bypass");
   a_lock_qualify: assert property ($rose(lock) |->
      $past(loop_locked_in, 8))
      else $error("lock rose before qualification");
   cover property ($rose(lock));
   cover property ($rose(irq));
   cover property (pins.pll_bypass && pins.ref_input_select);
endmodule : clk_buffer_ctrl_assertions
bind clk_buffer_ctrl clk_buffer_ctrl_assertions u_clk_buffer_ctrl_assertions (
   .ref_clk(ref_clk), .rst(rst), .loop_locked_in(loop_locked_in),
   .pins(pins), .req(req), .rdata(rdata), .lock(lock), .irq(irq),
   .clk_out_oe_n(clk_out_oe_n), .slew_fast(slew_fast),
   .out_impedance(out_impedance), .bank_std(bank_std)
);
`default_nettype wire

/* File: testbench/board_model.sv */
// Purpose: board side: references, loop model and reset pin
// Assumes: levels change only on ref_clk edges
// Notes: hold_refs parks the references so a wrong pick is visible
`timescale 1ns/100ps
`default_nettype none
module board_model (
   input wire logic ref_clk,
   input wire logic hold_refs,
   input wire logic loop_ok,
   input wire logic drive_reset,
   input wire logic reset_level_n,
   output logic ref_a,
   output logic ref_b,
   output logic vco,
   output logic loop_locked,
   output logic reset_n
);
   logic [3:0] cnt_ff = 4'h0;
   always_ff @(posedge ref_clk) cnt_ff <= cnt_ff + 4'h1;
   // references run slower than the oscillator so the paths differ
   assign ref_a = hold_refs ? 1'b1 : cnt_ff[2];
   assign ref_b = hold_refs ? 1'b0 : cnt_ff[3];
   assign vco = cnt_ff[0];
   assign loop_locked = loop_ok;
   // pull-up keeps the pin inactive whenever the board lets go
   assign reset_n = drive_reset ? reset_level_n : 1'b1;
endmodule : board_model
`default_nettype wire

/* File: testbench/test_clk_buffer_ctrl.sv */
// Purpose: self-checking bench of the clock buffer control block
// Assumes: register reads answer in the following cycle
// Notes: reads are checked by a watcher against a queue of notes
`timescale 1ns/100ps
`default_nettype none
module test_clk_buffer_ctrl;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic sel = 1'b0, byp = 1'b0, xn = 1'b1, yn = 1'b1;
   logic hold = 1'b0, lk = 1'b0, drv = 1'b0, lvl = 1'b1, rd_d = 1'b0;
   logic ra, rb, vco, ll, rn, lock, irq;
   logic [31:0] rdata;
   logic [19:0] clk_out, oe_n, slew;
   logic [59:0] imp;
   logic [29:0] bstd;
   clk_ctrl_pkg::ctrl_pins_t pins;
   clk_ctrl_pkg::reg_req_t req = '0;
   logic [31:0] rd_q[$];
   int fails = 0;
   int comparisons = 0;
   always #5 ref_clk = ~ref_clk;
   assign pins = '{sel, byp, rn, xn, yn};
   board_model u_board_model (.ref_clk(ref_clk), .hold_refs(hold),
      .loop_ok(lk), .drive_reset(drv), .reset_level_n(lvl), .ref_a(ra),
      .ref_b(rb), .vco(vco), .loop_locked(ll), .reset_n(rn));
   clk_buffer_ctrl u_clk_buffer_ctrl (.ref_clk(ref_clk), .rst(rst),
      .ref_clock_a_in(ra), .ref_clock_b_in(rb), .feedback_in(clk_out[0]),
      .vco_in(vco), .loop_locked_in(ll), .pins(pins), .req(req),
      .rdata(rdata), .lock(lock), .irq(irq), .clk_out(clk_out),
      .clk_out_oe_n(oe_n), .slew_fast(slew), .out_impedance(imp),
      .bank_std(bstd));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic chk(input string n, input logic [63:0] e,
                      input logic [63:0] g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask : chk
   always @(posedge ref_clk) begin
      if (rd_d) chk("rdata", 64'(rd_q.pop_front()), 64'(rdata));
      rd_d <= req.rd;
   end
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge ref_clk);
      req <= '0;
   endtask : wr
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      @(posedge ref_clk);
      req <= '{1'b0, 1'b1, a, 32'h0};
      @(posedge ref_clk);
      req <= '0;
   endtask : rd
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : step
   task automatic finish_test;
      if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test
   initial begin
      #100000;
      fails++;
      finish_test();
   end
   initial begin
      logic [31:0] s, v;
      logic [19:0] es, eo;
      logic [59:0] ei;
      logic [1:0] m[20];
      int n;
      s = 32'hDAC1B981;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      rd(clk_ctrl_pkg::REG_LOCK_COUNT, 32'h00000040);
      rd(clk_ctrl_pkg::REG_IRQ_MASK, 32'h00000000);
      wr(5'h1F, 32'hFFFFFFFF);
      rd(5'h1F, clk_ctrl_pkg::UNMAPPED_READ);
      // random driver settings, output mode cycles through all four
      for (int i = 0; i < 20; i++) begin
         s = lfsr(s);
         v = {26'h0, s[5:2], 2'(i % 4)};
         m[i] = v[1:0];
         es[i] = v[5];
         ei[3*i +: 3] = v[4:2];
         wr(5'(8 + i), v);
         rd(5'(8 + i), v);
      end
      s = lfsr(s);
      wr(clk_ctrl_pkg::REG_BANK_STD, {2'h0, s[29:0]});
      step(2);
      chk("bank_std", 64'(s[29:0]), 64'(bstd));
      chk("slew", 64'(es), 64'(slew));
      chk("impedance", 64'(ei), 64'(imp));
      for (int c = 0; c < 4; c++) begin
         @(posedge ref_clk);
         xn <= c[0];
         yn <= c[1];
         step(3);
         for (int i = 0; i < 20; i++)
            eo[i] = m[i] == 2'h0 ? 1'b0 : m[i] == 2'h1 ? 1'b1 :
                    m[i] == 2'h2 ? c[0] : c[1];
         chk("oe_n", 64'(eo), 64'(oe_n));
      end
      wr(clk_ctrl_pkg::REG_LOCK_COUNT, 32'h00000008);
      wr(clk_ctrl_pkg::REG_IRQ_MASK, 32'h00000003);
      @(posedge ref_clk);
      lk <= 1'b1;
      n = 0;
      while (lock !== 1'b1 && n < 40) begin
         step(1);
         n++;
      end
      chk("lock_wait", 64'(n >= 9 && n <= 10), 64'h1);
      step(3);
      chk("irq_gain", 64'h1, 64'(irq));
      rd(clk_ctrl_pkg::REG_IRQ_STATUS, 32'h00000001);
      wr(clk_ctrl_pkg::REG_IRQ_STATUS, 32'h00000001);
      step(3);
      chk("irq_clear", 64'h0, 64'(irq));
      @(posedge ref_clk);
      drv <= 1'b1;
      lvl <= 1'b0;
      step(2);
      chk("lock_pin_reset", 64'h0, 64'(lock));
      rd(clk_ctrl_pkg::REG_STATUS, 32'h00000008);
      step(3);
      chk("irq_loss", 64'h1, 64'(irq));
      wr(clk_ctrl_pkg::REG_IRQ_MASK, 32'h00000000);
      step(3);
      chk("irq_masked", 64'h0, 64'(irq));
      rd(clk_ctrl_pkg::REG_IRQ_STATUS, 32'h00000002);
      wr(clk_ctrl_pkg::REG_IRQ_STATUS, 32'h00000003);
      @(posedge ref_clk);
      drv <= 1'b0;
      hold <= 1'b1;
      byp <= 1'b1;
      step(8);
      chk("clk_out_ref_a", 64'hFFFFF, 64'(clk_out));
      chk("lock_bypass", 64'h0, 64'(lock));
      @(posedge ref_clk);
      sel <= 1'b1;
      step(8);
      chk("clk_out_ref_b", 64'h0, 64'(clk_out));
      rd(clk_ctrl_pkg::REG_STATUS, 32'h00000006);
      @(posedge ref_clk);
      byp <= 1'b0;
      // oscillator toggles every cycle, so /2^d gives 8 >> d changes
      for (int d = 0; d < 3; d++) begin
         wr(clk_ctrl_pkg::REG_DIVIDE, 32'(d));
         rd(clk_ctrl_pkg::REG_DIVIDE, 32'(d));
         step(8);
         n = 0;
         for (int k = 0; k < 8; k++) begin
            es = clk_out;
            step(1);
            if (clk_out !== es) n++;
         end
         chk("vco_path", 64'(8 >> d), 64'(n));
      end
      step(4);
      finish_test();
   end
endmodule : test_clk_buffer_ctrl
`default_nettype wire
